// file: fetc_pkg.sv
// Shared constants, register map and carrier types of the FET control block
package fetc_pkg;
    // Bus geometry
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PRECHARGE_FET_DRIVE_THR = 8'h0C;
    localparam logic [7:0] REG_BODY_THR = 8'h10;
    localparam logic [7:0] REG_PREDISCHARGE_FET_DRIVE_TIME = 8'h14;
    localparam logic [7:0] REG_PIN_CFG = 8'h18;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [31:0] THR_RST = 32'h0000_0000;
    localparam logic [31:0] PREDISCHARGE_FET_DRIVE_TIME_RST = 32'h0000_0FA0;
    localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Indicator pin functions
    localparam logic [1:0] IND_FAULT_OUT = 2'h0;
    localparam logic [1:0] IND_THERM_IN = 2'h1;
    localparam logic [1:0] IND_ADC_IN = 2'h2;
    localparam logic [1:0] IND_LED_SINK = 2'h3;
    // Number of asynchronous inputs brought onto clk
    localparam int SYNC_W = 7;

    // Control register layout
    typedef struct packed {
        logic [20:0] rsvd;
        logic pump_undervoltage_lockout_turnoff;   // 1: turn FETs off, 0: only hold off turn-on
        logic pump_undervoltage_lockout_en;        // Undervoltage lockout reaction enabled
        logic series_cfg;     // 1: series FETs, 0: parallel
        logic predsg_en;      // Predischarge before discharge FET
        logic ot_dsg;         // Over temperature acts on discharge side
        logic ot_chg;         // Over temperature acts on charge side
        logic dsg_kill_sel;   // Discharge kill pin used for FET turn-off
        logic chg_kill_sel;   // Charge kill pin used for FET turn-off
        logic host_recovery;  // 1: faults latch until host clears
        logic dsg_req;        // Discharge FET turn-on request
        logic chg_req;        // Charge FET turn-on request
    } fetc_ctrl_t;

    // Host command disables
    typedef struct packed {
        logic [29:0] rsvd;
        logic dsg_off;
        logic chg_off;
    } fetc_cmd_t;

    // Fault inputs from the comparators and charge pump
    typedef struct packed {
        logic pump_undervoltage_lockout;
        logic over_temp_fault;
        logic discharge_overcurrent_fault;
        logic charge_overcurrent_fault;
        logic short_circuit_fault;
    } fetc_fault_t;

    // Gate driver enables
    typedef struct packed {
        logic predischarge_fet_drive;
        logic precharge_fet_drive;
        logic discharge_fet_drive;
        logic charge_fet_drive;
    } fetc_drive_t;

    // Status register layout
    typedef struct packed {
        logic [22:0] rsvd;
        fetc_drive_t drive;   // Live driver state, read only
        fetc_fault_t fault;   // Sticky, write one to clear
    } fetc_status_t;

    // One multifunction pin
    typedef struct packed {
        logic out;
        logic oe;
    } fetc_pin_t;

    // Discharge sequencing states
    typedef enum logic [1:0] {DSG_IDLE, DSG_PRE, DSG_ON} fetc_dsg_state_t;
endpackage

// file: fetc_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/10ps
module fetc_sync import fetc_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [SYNC_W-1:0] async_in,
    output logic [SYNC_W-1:0] sync_out
);
    // First stage, read only by the second stage
    logic [SYNC_W-1:0] meta;

    // One pair of flops per bit
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule

// file: fetc_top.sv
// Protection FET control: fault merging, kill pins, pre-FET sequencing
`timescale 1ns/10ps
module fetc_top import fetc_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [WB_AW-1:0] wb_adr,
    input wire logic [WB_DW-1:0] wb_dat_w,
    input wire logic [3:0] wb_sel,
    output logic [WB_DW-1:0] wb_dat_r,
    output logic wb_ack,
    input wire logic charge_fet_kill_pin,
    input wire logic discharge_fet_kill_pin,
    input wire fetc_fault_t fault_in,
    input wire logic [15:0] min_cell_mv,
    input wire logic [15:0] pack_mv,
    input wire logic signed [15:0] pack_current,
    output fetc_drive_t drive,
    output fetc_pin_t charge_block_indicator,
    output fetc_pin_t discharge_block_indicator,
    output logic [1:0] charge_block_indicator_func,
    output logic [1:0] discharge_block_indicator_func,
    output logic [1:0] kill_pin_alt,
    output logic alert
);
    // Byte-lane merge, used by every writable register
    function automatic logic [31:0] merge_sel(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register file state
    fetc_ctrl_t ctrl, next_ctrl;
    fetc_cmd_t cmd, next_cmd;
    fetc_fault_t sticky, next_sticky;
    logic [31:0] precharge_fet_drive_thr, next_precharge_fet_drive_thr;     // [31:16] stop, [15:0] start
    logic [31:0] body_thr, next_body_thr;     // [31:16] dsg, [15:0] chg
    logic [31:0] predischarge_fet_drive_time, next_predischarge_fet_drive_time;   // Predischarge length, cycles
    logic [31:0] pin_cfg, next_pin_cfg;       // [3:2] dsg, [1:0] chg pin
    logic [WB_DW-1:0] next_dat_r;
    logic next_ack;

    // Synchronised inputs
    logic [SYNC_W-1:0] sync_v;
    logic kill_c, kill_d;
    fetc_fault_t flt;

    // Pins and analog flags cross into clk before use
    fetc_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({fault_in, discharge_fet_kill_pin, charge_fet_kill_pin}),
        .sync_out(sync_v)
    );
    assign kill_c = sync_v[0];
    assign kill_d = sync_v[1];
    assign flt = fetc_fault_t'(sync_v[SYNC_W-1:2]);

    // Bus request seen once, answered next cycle
    logic req, wr_now;
    assign req = wb_cyc & wb_stb & ~wb_ack;
    // Write lands on the edge where the master samples ack
    assign wr_now = wb_cyc & wb_stb & wb_ack & wb_we;

    // Blocking reasons
    logic scd_blk, occ_blk, ocd_blk, ot_blk, any_fault;
    logic chg_fault, dsg_fault, kc_act, kd_act;
    logic uv_c, uv_d, chg_block, dsg_block;
    logic [16:0] dsg_mag, chg_mag;
    logic dsg_over, chg_over;
    logic precharge_fet_drive_mode, next_precharge_fet_drive_mode;
    logic bd_c, next_bd_c, bd_d, next_bd_d;
    fetc_dsg_state_t st, next_st;
    logic [15:0] cnt, next_cnt;
    fetc_drive_t next_drive;
    fetc_pin_t next_cind, next_dind;
    logic [1:0] next_alt;
    logic next_alert;
    logic dsg_allow;

    // Fault merging and blocking terms
    always_comb begin
        // Short circuit always latches until cleared
        scd_blk = flt.short_circuit_fault | sticky.short_circuit_fault;
        // Host recovery keeps latched faults in force
        occ_blk = flt.charge_overcurrent_fault
            | (ctrl.host_recovery & sticky.charge_overcurrent_fault);
        ocd_blk = flt.discharge_overcurrent_fault
            | (ctrl.host_recovery & sticky.discharge_overcurrent_fault);
        ot_blk = flt.over_temp_fault
            | (ctrl.host_recovery & sticky.over_temp_fault);
        any_fault = scd_blk | occ_blk | ocd_blk | ot_blk;
        chg_fault = scd_blk | occ_blk | (ctrl.ot_chg & ot_blk);
        dsg_fault = scd_blk | ocd_blk | (ctrl.ot_dsg & ot_blk);
        // Unselected pins stay out of the FET path
        kc_act = ctrl.chg_kill_sel & kill_c;
        kd_act = ctrl.dsg_kill_sel & kill_d;
        // Undervoltage: hold off turn-on, or force off
        uv_c = ctrl.pump_undervoltage_lockout_en & flt.pump_undervoltage_lockout
            & (ctrl.pump_undervoltage_lockout_turnoff | ~drive.charge_fet_drive);
        uv_d = ctrl.pump_undervoltage_lockout_en & flt.pump_undervoltage_lockout
            & (ctrl.pump_undervoltage_lockout_turnoff | ~drive.discharge_fet_drive);
        // Every reason ORed into one disable per side
        chg_block = chg_fault | kc_act | cmd.chg_off | uv_c;
        dsg_block = dsg_fault | kd_act | cmd.dsg_off | uv_d;
        // Current magnitudes, positive current is charging
        dsg_mag = 17'(-pack_current);
        chg_mag = 17'(pack_current);
        dsg_over = ~pack_current[15] & 1'b0 | (pack_current[15]
            & (dsg_mag > {1'b0, body_thr[31:16]}));
        chg_over = ~pack_current[15] & (chg_mag > {1'b0, body_thr[15:0]});
    end

    // Precharge, body diode and discharge sequencing decisions
    always_comb begin
        next_precharge_fet_drive_mode = precharge_fet_drive_mode;
        // Enter below start threshold, leave at stop level
        if (min_cell_mv < precharge_fet_drive_thr[15:0]) begin
            next_precharge_fet_drive_mode = 1'b1;
        end else if (pack_mv >= precharge_fet_drive_thr[31:16]) begin
            next_precharge_fet_drive_mode = 1'b0;
        end
        // Body diode guard holds while current stays high
        next_bd_c = ctrl.series_cfg & dsg_over & ~kc_act & ~scd_blk
            & (drive.discharge_fet_drive | drive.predischarge_fet_drive)
            & (bd_c | ~drive.charge_fet_drive);
        next_bd_d = ctrl.series_cfg & chg_over & ~kd_act & ~scd_blk
            & (drive.charge_fet_drive | drive.precharge_fet_drive)
            & (bd_d | ~drive.discharge_fet_drive);
        // Discharge turn-on sequence
        dsg_allow = ctrl.dsg_req & ~dsg_block;
        next_st = st;
        next_cnt = cnt;
        unique case (st)
            DSG_IDLE: begin
                if (dsg_allow && ctrl.predsg_en) begin
                    next_st = DSG_PRE;
                    next_cnt = predischarge_fet_drive_time[15:0];
                end else if (dsg_allow) begin
                    next_st = DSG_ON;
                end
            end
            DSG_PRE: begin
                if (!dsg_allow) begin
                    next_st = DSG_IDLE;
                end else if (cnt <= CNT_ONE) begin
                    next_st = DSG_ON;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            DSG_ON: begin
                if (!dsg_allow) begin
                    next_st = DSG_IDLE;
                end
            end
        endcase
        // Enables formed every cycle, registered below
        next_drive.charge_fet_drive = (ctrl.chg_req & ~next_precharge_fet_drive_mode
            & ~chg_block) | next_bd_c;
        next_drive.precharge_fet_drive = ctrl.chg_req & next_precharge_fet_drive_mode
            & ~chg_block & ~any_fault;
        next_drive.discharge_fet_drive = (next_st == DSG_ON) | next_bd_d;
        next_drive.predischarge_fet_drive = (next_st == DSG_PRE);
    end

    // Indicators and alternate pin data
    always_comb begin
        // Active-high fault level only in digital output mode
        next_cind.oe = (pin_cfg[1:0] == IND_FAULT_OUT);
        next_cind.out = next_cind.oe & chg_fault;
        next_dind.oe = (pin_cfg[3:2] == IND_FAULT_OUT);
        next_dind.out = next_dind.oe & dsg_fault;
        next_alt = {~ctrl.dsg_kill_sel & kill_d, ~ctrl.chg_kill_sel & kill_c};
    end

    // Register file next values and read mux
    always_comb begin
        next_ctrl = ctrl;
        next_cmd = cmd;
        next_precharge_fet_drive_thr = precharge_fet_drive_thr;
        next_body_thr = body_thr;
        next_predischarge_fet_drive_time = predischarge_fet_drive_time;
        next_pin_cfg = pin_cfg;
        next_sticky = sticky;
        if (wr_now) begin
            unique case (wb_adr)
                REG_CTRL: next_ctrl = fetc_ctrl_t'(merge_sel(ctrl, wb_dat_w, wb_sel));
                REG_CMD: next_cmd = fetc_cmd_t'(merge_sel(cmd, wb_dat_w, wb_sel));
                REG_STATUS: begin
                    // Write one clears the sticky bit
                    next_sticky = fetc_fault_t'(sticky
                        & ~merge_sel(32'h0000_0000, wb_dat_w, wb_sel));
                end
                REG_PRECHARGE_FET_DRIVE_THR: next_precharge_fet_drive_thr = merge_sel(precharge_fet_drive_thr, wb_dat_w, wb_sel);
                REG_BODY_THR: next_body_thr = merge_sel(body_thr, wb_dat_w, wb_sel);
                REG_PREDISCHARGE_FET_DRIVE_TIME: next_predischarge_fet_drive_time = merge_sel(predischarge_fet_drive_time, wb_dat_w, wb_sel);
                REG_PIN_CFG: next_pin_cfg = merge_sel(pin_cfg, wb_dat_w, wb_sel);
                default: ;
            endcase
        end
        // A fault arriving with the clear still wins
        next_sticky = next_sticky | flt;
        next_alert = |next_sticky;
        // Unmapped reads answer zero
        next_dat_r = wb_dat_r;
        if (req) begin
            unique case (wb_adr)
                REG_CTRL: next_dat_r = ctrl;
                REG_CMD: next_dat_r = cmd;
                REG_STATUS: next_dat_r = {23'h0, drive, sticky};
                REG_PRECHARGE_FET_DRIVE_THR: next_dat_r = precharge_fet_drive_thr;
                REG_BODY_THR: next_dat_r = body_thr;
                REG_PREDISCHARGE_FET_DRIVE_TIME: next_dat_r = predischarge_fet_drive_time;
                REG_PIN_CFG: next_dat_r = pin_cfg;
                default: next_dat_r = 32'h0000_0000;
            endcase
        end
        next_ack = req;
    end

    // All state registered on every edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= fetc_ctrl_t'(CTRL_RST);
            cmd <= fetc_cmd_t'(CMD_RST);
            sticky <= fetc_fault_t'(5'h00);
            precharge_fet_drive_thr <= THR_RST;
            body_thr <= THR_RST;
            predischarge_fet_drive_time <= PREDISCHARGE_FET_DRIVE_TIME_RST;
            pin_cfg <= PIN_CFG_RST;
            wb_dat_r <= 32'h0000_0000;
            wb_ack <= 1'b0;
            precharge_fet_drive_mode <= 1'b0;
            bd_c <= 1'b0;
            bd_d <= 1'b0;
            st <= DSG_IDLE;
            cnt <= CNT_ZERO;
            drive <= fetc_drive_t'(4'h0);
            charge_block_indicator <= fetc_pin_t'(2'h0);
            discharge_block_indicator <= fetc_pin_t'(2'h0);
            kill_pin_alt <= 2'h0;
            alert <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            cmd <= next_cmd;
            sticky <= next_sticky;
            precharge_fet_drive_thr <= next_precharge_fet_drive_thr;
            body_thr <= next_body_thr;
            predischarge_fet_drive_time <= next_predischarge_fet_drive_time;
            pin_cfg <= next_pin_cfg;
            wb_dat_r <= next_dat_r;
            wb_ack <= next_ack;
            precharge_fet_drive_mode <= next_precharge_fet_drive_mode;
            bd_c <= next_bd_c;
            bd_d <= next_bd_d;
            st <= next_st;
            cnt <= next_cnt;
            drive <= next_drive;
            charge_block_indicator <= next_cind;
            discharge_block_indicator <= next_dind;
            kill_pin_alt <= next_alt;
            alert <= next_alert;
        end
    end

    // Function selects go straight to the pad mux
    assign charge_block_indicator_func = pin_cfg[1:0];
    assign discharge_block_indicator_func = pin_cfg[3:2];

    // Checks
    sequence s_kill_c;
        kc_act ##0 !scd_blk;
    endsequence
    sequence s_pre_then_on;
        drive.predischarge_fet_drive ##1 drive.discharge_fet_drive;
    endsequence

    kill_chg_off_a: assert property (@(posedge clk) disable iff (!resetn)
        s_kill_c |=> !drive.charge_fet_drive && !drive.precharge_fet_drive)
        else $error("charge FET on while kill pin asserted");
    cmd_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (cmd.dsg_off && !bd_d && !next_bd_d) |=> !drive.discharge_fet_drive)
        else $error("discharge FET on under command disable");
    scd_all_off_a: assert property (@(posedge clk) disable iff (!resetn)
        sticky.short_circuit_fault |=> drive == fetc_drive_t'(4'h0))
        else $error("FET on during latched short circuit");
    precharge_fet_drive_fault_a: assert property (@(posedge clk) disable iff (!resetn)
        any_fault |=> !drive.precharge_fet_drive)
        else $error("precharge FET on during a fault");
    predsg_seq_a: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl.predsg_en && !bd_d && $rose(drive.discharge_fet_drive))
        |-> $past(drive.predischarge_fet_drive))
        else $error("discharge FET on without predischarge");
    parallel_no_bd_a: assert property (@(posedge clk) disable iff (!resetn)
        (!ctrl.series_cfg && chg_block) |=> !drive.charge_fet_drive)
        else $error("body diode turn-on in parallel configuration");
    partial_latch_a: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl.host_recovery && sticky.charge_overcurrent_fault && !next_bd_c)
        |=> !drive.charge_fet_drive)
        else $error("charge FET re-enabled before host release");
    auto_recover_a: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl.chg_req && !chg_block && !next_precharge_fet_drive_mode) |=> drive.charge_fet_drive)
        else $error("charge FET not re-enabled with no blocker");
    ind_chg_a: assert property (@(posedge clk) disable iff (!resetn)
        (chg_fault && pin_cfg[1:0] == IND_FAULT_OUT)
        |=> charge_block_indicator.out && charge_block_indicator.oe)
        else $error("charge indicator missing a charge fault");
    alert_a: assert property (@(posedge clk) disable iff (!resetn)
        (|flt) |=> alert ##0 (|sticky))
        else $error("fault without alert");
    predsg_cover_seq_a: assert property (@(posedge clk) disable iff (!resetn)
        (st == DSG_PRE && cnt <= CNT_ONE && dsg_allow && !next_bd_d)
        |-> s_pre_then_on ##0 !drive.predischarge_fet_drive)
        else $error("predischarge did not hand over to discharge");
endmodule

// file: fetc_host_model.sv
// Host-side model: kill pins and fault levels toward the block
`timescale 1ns/10ps
module fetc_host_model import fetc_pkg::*; (
    input wire logic clk,
    input wire logic ck_req,
    input wire logic dk_req,
    input wire logic auto_kill,
    input wire fetc_fault_t fault_req,
    input wire fetc_pin_t chg_ind,
    output logic charge_fet_kill_pin = 1'b0,
    output logic discharge_fet_kill_pin = 1'b0,
    output fetc_fault_t fault_in = 5'h00
);
    // Indicator taken as interrupt, kill held until host lets go
    logic held = 1'b0;
    // Pins move just after the edge, like a real host port
    always @(posedge clk) begin
        held <= auto_kill & (held | chg_ind.out);
        charge_fet_kill_pin <= ck_req | (auto_kill & (held | chg_ind.out));
        discharge_fet_kill_pin <= dk_req;
        fault_in <= fault_req;
    end
endmodule

// file: test_protection_fet_control.sv
// Self-checking bench of the protection FET control block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_protection_fet_control import fetc_pkg::*;;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ck_req = 1'b0, dk_req = 1'b0, auto_kill = 1'b0, ack, ck, dk, alert;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, rd, q, seed = 32'h4EE7;
    logic [1:0] cfn, dfn, alt;
    fetc_fault_t fault_req = 5'h00, fault_in;
    logic [15:0] min_mv = 16'hFFFF, pack_mv = 16'h0000, mag;
    logic signed [15:0] cur = 16'sh0000;
    fetc_drive_t drv;
    fetc_pin_t cbi, dbi;
    int miscompares = 0, n_compared = 0, n, k;
    // Per-case tables: fault, drive during, drive after, indicators
    fetc_fault_t fv [3] = '{5'h02, 5'h04, 5'h01};
    logic [3:0] fe [3] = '{4'h2, 4'h1, 4'h0};
    logic [3:0] re [3] = '{4'h3, 4'h3, 4'h0};
    logic [1:0] ie [3] = '{2'h2, 2'h1, 2'h3};
    logic [31:0] ctl [3] = '{32'h102, 32'h002, 32'h101};
    logic [3:0] bd [3] = '{4'h3, 4'h2, 4'h3};
    logic [3:0] bs [3] = '{4'h2, 4'h2, 4'h1};

    fetc_top u_dut (.clk(clk), .resetn(resetn), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_dat_w(dw), .wb_sel(4'hF), .wb_dat_r(rd), .wb_ack(ack),
        .charge_fet_kill_pin(ck), .discharge_fet_kill_pin(dk), .fault_in(fault_in),
        .min_cell_mv(min_mv), .pack_mv(pack_mv), .pack_current(cur), .drive(drv),
        .charge_block_indicator(cbi), .discharge_block_indicator(dbi),
        .charge_block_indicator_func(cfn), .discharge_block_indicator_func(dfn),
        .kill_pin_alt(alt), .alert(alert));
    fetc_host_model u_host (.clk(clk), .ck_req(ck_req), .dk_req(dk_req),
        .auto_kill(auto_kill), .fault_req(fault_req), .chg_ind(cbi),
        .charge_fet_kill_pin(ck), .discharge_fet_kill_pin(dk), .fault_in(fault_in));

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    // Repeatable xorshift stream
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Output enable expected for an indicator function
    function automatic logic oe_exp(input logic [1:0] f);
        return f == IND_FAULT_OUT;
    endfunction
    // Classic cycle, held until ack is seen at an edge
    // Only the hang guard ends a wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // Pins reach the drive after three edges; allow five
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic flt(input fetc_fault_t f);
        @(posedge clk);
        fault_req <= f;
        settle();
    endtask
    // Drop live faults, then clear the sticky copies
    task automatic clr();
        flt(5'h00);
        wb(1'b1, REG_STATUS, 32'h1F);
        settle();
    endtask
    task automatic report_and_stop();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the expected run of a few hundred cycles
    initial begin
        #500000;
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        #1;
        `CHK(drv, 4'h0)
        wb(1'b0, REG_PREDISCHARGE_FET_DRIVE_TIME, 32'h0);
        `CHK(q, PREDISCHARGE_FET_DRIVE_TIME_RST)
        wb(1'b0, 8'h1C, 32'h0);
        `CHK(q, 32'h0)
        $display("reset done");
        // Both overcurrent faults and short circuit, autonomous recovery except short circuit, indicators and alert
        wb(1'b1, REG_CTRL, 32'h3);
        settle();
        `CHK(drv, 4'h3)
        for (int i = 0; i < 3; i++) begin
            flt(fv[i]);
            `CHK(drv, fe[i])
            `CHK({cbi.out, dbi.out}, ie[i])
            `CHK(alert, 1'b1)
            flt(5'h00);
            `CHK(drv, re[i])
            wb(1'b0, REG_STATUS, 32'h0);
            `CHK(q[4:0], fv[i])
            clr();
            `CHK(drv, 4'h3)
            `CHK(alert, 1'b0)
        end
        // Over temperature routed to the charge side only
        wb(1'b1, REG_CTRL, 32'h23);
        flt(5'h08);
        `CHK(drv, 4'h2)
        `CHK({cbi.out, dbi.out}, 2'h2)
        clr();
        `CHK(drv, 4'h3)
        $display("faults done");
        // Latched faults hold until the host clears them
        wb(1'b1, REG_CTRL, 32'h7);
        flt(5'h02);
        flt(5'h00);
        `CHK(drv, 4'h2)
        clr();
        `CHK(drv, 4'h3)
        $display("host recovery done");
        // Kill pins: unselected, selected, with command and live fault
        @(posedge clk);
        ck_req <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h3);
        settle();
        `CHK(drv, 4'h3)
        `CHK(alt, 2'h1)
        wb(1'b1, REG_CTRL, 32'h1B);
        settle();
        `CHK(drv, 4'h2)
        wb(1'b1, REG_CMD, 32'h2);
        @(posedge clk);
        ck_req <= 1'b0;
        settle();
        `CHK(drv, 4'h1)
        wb(1'b1, REG_CMD, 32'h0);
        @(posedge clk);
        dk_req <= 1'b1;
        flt(5'h04);
        @(posedge clk);
        dk_req <= 1'b0;
        settle();
        `CHK(drv, 4'h1)
        clr();
        `CHK(drv, 4'h3)
        // Host reacts to the indicator by holding the kill pin
        @(posedge clk);
        auto_kill <= 1'b1;
        flt(5'h02);
        clr();
        `CHK(drv, 4'h2)
        @(posedge clk);
        auto_kill <= 1'b0;
        settle();
        `CHK(drv, 4'h3)
        $display("kill pins done");
        // Precharge below start threshold, off on fault, left at stop level
        wb(1'b1, REG_PRECHARGE_FET_DRIVE_THR, 32'h0FA0_0BB8);
        @(posedge clk);
        min_mv <= 16'h09C4;
        pack_mv <= 16'h0DAC;
        wb(1'b1, REG_CTRL, 32'h1);
        settle();
        `CHK(drv, 4'h4)
        flt(5'h02);
        `CHK(drv, 4'h0)
        clr();
        @(posedge clk);
        pack_mv <= 16'h0FA0;
        min_mv <= 16'hFFFF;
        settle();
        `CHK(drv, 4'h1)
        $display("precharge done");
        // Predischarge for a random span, then handover in one edge
        n = 2 + (rnd() % 8);
        wb(1'b1, REG_PREDISCHARGE_FET_DRIVE_TIME, 32'(n));
        wb(1'b1, REG_CTRL, 32'h80);
        settle();
        wb(1'b1, REG_CTRL, 32'h82);
        #1;
        k = 0;
        while (drv.predischarge_fet_drive !== 1'b1 && k < 8) begin
            @(posedge clk); #1; k++;
        end
        k = 0;
        while (drv === 4'h8 && k < 40) begin
            @(posedge clk); #1; k++;
        end
        `CHK(k, n)
        `CHK(drv, 4'h2)
        $display("predischarge done");
        // Body-diode override: series both ways, parallel never
        wb(1'b1, REG_BODY_THR, 32'h0064_0064);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, REG_CTRL, ctl[i]);
            mag = 16'(101 + (rnd() % 500));
            @(posedge clk);
            cur <= (i == 2) ? mag : -mag;
            settle();
            `CHK(drv, bd[i])
            @(posedge clk);
            cur <= 16'sh0000;
            settle();
            `CHK(drv, bs[i])
        end
        $display("body diode done");
        // Every indicator function, fault on both sides
        flt(5'h06);
        for (int f = 0; f < 4; f++) begin
            wb(1'b1, REG_PIN_CFG, 32'(f * 5));
            settle();
            `CHK(cfn, 2'(f))
            `CHK(dfn, 2'(f))
            `CHK({cbi.oe, dbi.oe}, {2{oe_exp(2'(f))}})
        end
        clr();
        $display("indicators done");
        // Pump undervoltage: turn off, then hold off while still low
        wb(1'b1, REG_CTRL, 32'h603);
        flt(5'h10);
        `CHK(drv, 4'h0)
        wb(1'b1, REG_CTRL, 32'h203);
        settle();
        `CHK(drv, 4'h0)
        clr();
        `CHK(drv, 4'h3)
        $display("undervoltage done");
        report_and_stop();
    end
endmodule
